//--- design/agc_power_detect_and_timing.v
// Summary of operation
// - Mean-square power of decimated halfband samples.
// - Window is eight times two to exponent.
// - Use latest complete measurement, drop partial.
// - Two inner thresholds, coded minus(dBFS plus 6).
// - Three states: period, settle gap, five cycles.
// - Update period equals count plus gap plus five.
// - Fast attack allows decrease during period state.
// - Increase only at period or interval end.
// - Decrease starts gap counter, blocks further decreases.
// - Period state waits for gap counter expiry.
// - Late decrease deferred to next period.
// - End blocking can be disabled.
// - Period expiry resets measurement and peak counts.
// - Period counter loads at receive enable, counts after hold.
// - Sync pulse on chosen pin restarts period.
// - Sync pin selectable among sixteen pins.
// - Loop held inactive after enable for hold.
// - Machine runs from the AGC clock.
// - Period count up to 4194303, default 11520.
// - Settle gap 0 to 127, default 16.
// - Hold time 0 to 63, default 10.
//
// Register access over AXI4-Lite and the register addresses were decided locally.
`timescale 1ns/1ps
`include "agc_timing_defs.vh"
`default_nettype none
module agc_power_detect_and_timing (
   // Clock and reset; the AGC clock.
   input wire clock,
   input wire rst,
   // AXI4-Lite write address.
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   // AXI4-Lite write data.
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   // AXI4-Lite write response.
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read address.
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   // AXI4-Lite read data.
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // Decimated samples after the halfband stage.
   input wire [15:0] sample_i,
   input wire [15:0] sample_q,
   input wire sample_valid,
   // Gain requests from the peak detectors and low under-range interval end.
   input wire attack_req,
   input wire recover_req,
   input wire low_interval_done,
   // General-purpose digital pins.
   input wire [15:0] digital_gp_pin,
   // Gain loop outputs.
   output reg gain_decrease,
   output reg gain_increase,
   output reg measure_reset,
   output reg low_power_flag,
   output reg high_power_flag,
   output reg [1:0] timing_state
);
   localparam ST_PERIOD = 2'h0;
   localparam ST_SETTLE = 2'h1;
   localparam ST_FIXED = 2'h2;

   // Registers.
   reg [31:0] ctrl_ff;
   reg [21:0] period_ff;
   reg [6:0] settle_ff;
   reg [5:0] hold_ff;
   reg [3:0] window_ff;
   reg [15:0] thresh_ff;
   reg [31:0] power_ff;
   reg power_ok_ff;
   // Bus slave state.
   reg aw_ok_ff;
   reg w_ok_ff;
   reg [7:0] awaddr_ff;
   reg [31:0] wdata_ff;
   reg [3:0] wstrb_ff;
   // Timing state.
   reg [21:0] pcnt_ff;
   reg [6:0] gcnt_ff;
   reg [6:0] scnt_ff;
   reg [5:0] hcnt_ff;
   reg rx_en_d_ff;
   reg defer_ff;
   reg [15:0] pin_s1_ff;
   reg [15:0] pin_s2_ff;
   reg sync_d_ff;
   // Power accumulator; wide enough for the longest window of full-scale samples.
   reg [46:0] acc_ff;
   reg [18:0] scnt_win_ff;

   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0] strb;
      integer k;
      begin
         merge = old;
         for (k = 0; k < 4; k = k + 1) begin
            if (strb[k]) begin
               merge[k*8 +: 8] = nw[k*8 +: 8];
            end
         end
      end
   endfunction

   function mapped;
      input [7:0] a;
      begin
         mapped = (a <= `OFF_STROBE) && (a[1:0] == 2'h0);
      end
   endfunction

   // The reload is one below the setting so the period state lasts exactly that long.
   function [21:0] period_load;
      input [21:0] p;
      begin
         period_load = (p == 22'h000000) ? 22'h000000 : p - 22'h000001;
      end
   endfunction

   wire rx_en = ctrl_ff[`CTRL_RX_EN];
   wire [3:0] pin_sel = ctrl_ff[`CTRL_PIN_LO +: 4];
   wire sync_lvl = pin_s2_ff[pin_sel];
   wire sync_pulse = ctrl_ff[`CTRL_SYNC_EN] && sync_lvl && !sync_d_ff;
   wire rx_rise = rx_en && !rx_en_d_ff;
   wire holding = (hcnt_ff != 6'h00);
   wire gap_run = (gcnt_ff != 7'h00);
   wire fast_rec = ctrl_ff[`CTRL_FAST_REC];
   wire period_end = fast_rec ? low_interval_done : (pcnt_ff == 22'h000000);
   // Blocking zone: the last settle gap plus one cycle of the period state.
   wire near_end = ({15'h0000, settle_ff} >= pcnt_ff);
   wire block_on = ctrl_ff[`CTRL_BLOCK_EN];
   wire active = rx_en && !holding;
   wire atk_window = (timing_state == ST_PERIOD) && ctrl_ff[`CTRL_FAST_ATTACK];
   wire atk_allowed = active && atk_window && !gap_run && !(block_on && near_end);
   wire atk_now = atk_allowed && (attack_req || defer_ff);
   wire leave_period = active && (timing_state == ST_PERIOD) && period_end && !gap_run;
   wire [31:0] isq = sample_i * sample_i;
   wire [31:0] qsq = sample_q * sample_q;
   wire [46:0] acc_next = acc_ff + {15'h0000, isq >> 1} + {15'h0000, qsq >> 1};
   wire [46:0] mean_sq = acc_next >> (window_ff + 4'h3);
   wire [18:0] win_len = `WIN_BASE << window_ff;
   wire wr_go = aw_ok_ff && w_ok_ff && !s_axi_bvalid;
   // Register images with the write strobes applied.
   wire [31:0] wr_ctrl = merge(ctrl_ff, wdata_ff, wstrb_ff);
   wire [31:0] wr_period = merge({10'h000, period_ff}, wdata_ff, wstrb_ff);
   wire [31:0] wr_settle = merge({25'h0, settle_ff}, wdata_ff, wstrb_ff);
   wire [31:0] wr_hold = merge({26'h0, hold_ff}, wdata_ff, wstrb_ff);
   wire [31:0] wr_window = merge({28'h0, window_ff}, wdata_ff, wstrb_ff);
   wire [31:0] wr_thresh = merge({16'h0000, thresh_ff}, wdata_ff, wstrb_ff);

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `AXI_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= `AXI_OKAY;
         s_axi_rdata <= 32'h0000_0000;
         aw_ok_ff <= 1'b0;
         w_ok_ff <= 1'b0;
         awaddr_ff <= 8'h00;
         wdata_ff <= 32'h0000_0000;
         wstrb_ff <= 4'h0;
         ctrl_ff <= `CTRL_RST;
         period_ff <= `PERIOD_RST;
         settle_ff <= `SETTLE_RST;
         hold_ff <= `HOLD_RST;
         window_ff <= `WINDOW_RST;
         thresh_ff <= `THRESH_RST;
      end else begin
         s_axi_awready <= !aw_ok_ff && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !w_ok_ff && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_ok_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_ok_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_ok_ff <= 1'b0;
            w_ok_ff <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(awaddr_ff) ? `AXI_OKAY : `AXI_SLVERR;
            case (awaddr_ff)
               `OFF_CTRL: begin
                  ctrl_ff <= {20'h00000, wr_ctrl[11:8], 3'h0, wr_ctrl[4:0]};
               end
               `OFF_PERIOD: begin
                  period_ff <= wr_period[21:0];
               end
               `OFF_SETTLE: begin
                  settle_ff <= wr_settle[6:0];
               end
               `OFF_HOLD: begin
                  hold_ff <= wr_hold[5:0];
               end
               `OFF_WINDOW: begin
                  window_ff <= (wr_window[3:0] > 4'hb) ? 4'hb : wr_window[3:0];
               end
               `OFF_THRESH: begin
                  thresh_ff <= wr_thresh[15:0];
               end
               default: begin
                  // Read-only and unmapped words ignore writes.
               end
            endcase
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= mapped(s_axi_araddr) ? `AXI_OKAY : `AXI_SLVERR;
            case (s_axi_araddr)
               `OFF_CTRL: s_axi_rdata <= ctrl_ff;
               `OFF_PERIOD: s_axi_rdata <= {10'h000, period_ff};
               `OFF_SETTLE: s_axi_rdata <= {25'h0, settle_ff};
               `OFF_HOLD: s_axi_rdata <= {26'h0, hold_ff};
               `OFF_WINDOW: s_axi_rdata <= {28'h0, window_ff};
               `OFF_THRESH: s_axi_rdata <= {16'h0000, thresh_ff};
               `OFF_STATUS: s_axi_rdata <= {24'h0, power_ok_ff, gap_run, holding,
                                           defer_ff, high_power_flag, low_power_flag,
                                           timing_state};
               `OFF_POWER: s_axi_rdata <= power_ff;
               default: s_axi_rdata <= 32'h0000_0000;
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Sync pin crossing; the first stage feeds only the second.
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         pin_s1_ff <= 16'h0000;
         pin_s2_ff <= 16'h0000;
         sync_d_ff <= 1'b0;
      end else begin
         pin_s1_ff <= digital_gp_pin;
         pin_s2_ff <= pin_s1_ff;
         sync_d_ff <= sync_lvl;
      end
   end

   // Gain timing machine.
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         timing_state <= ST_PERIOD;
         pcnt_ff <= `PERIOD_RST;
         gcnt_ff <= 7'h00;
         scnt_ff <= 7'h00;
         hcnt_ff <= 6'h00;
         rx_en_d_ff <= 1'b0;
         defer_ff <= 1'b0;
         gain_decrease <= 1'b0;
         gain_increase <= 1'b0;
         measure_reset <= 1'b0;
      end else begin
         rx_en_d_ff <= rx_en;
         gain_decrease <= 1'b0;
         gain_increase <= 1'b0;
         measure_reset <= 1'b0;
         if (gap_run) begin
            gcnt_ff <= gcnt_ff - 7'h01;
         end
         if (holding) begin
            hcnt_ff <= hcnt_ff - 6'h01;
         end
         if (!rx_en || rx_rise) begin
            // Counting begins afresh at every receive enable.
            timing_state <= ST_PERIOD;
            pcnt_ff <= period_load(period_ff);
            hcnt_ff <= hold_ff;
            gcnt_ff <= 7'h00;
            defer_ff <= 1'b0;
         end else if (sync_pulse) begin
            timing_state <= ST_PERIOD;
            pcnt_ff <= period_load(period_ff);
         end else if (active) begin
            if (atk_now) begin
               gain_decrease <= 1'b1;
               gcnt_ff <= settle_ff;
               defer_ff <= 1'b0;
            end else if (attack_req && atk_window && block_on && near_end && !gap_run) begin
               defer_ff <= 1'b1;
            end
            case (timing_state)
               ST_PERIOD: begin
                  if (pcnt_ff != 22'h000000) begin
                     pcnt_ff <= pcnt_ff - 22'h000001;
                  end
                  if (leave_period) begin
                     // Recovery only here, so it lines up with the period edge.
                     gain_increase <= recover_req;
                     measure_reset <= 1'b1;
                     // A zero settle gap goes straight on to the fixed delay.
                     if (settle_ff == 7'h00) begin
                        timing_state <= ST_FIXED;
                        scnt_ff <= `FIXED_GAP - 7'h01;
                     end else begin
                        timing_state <= ST_SETTLE;
                        scnt_ff <= settle_ff - 7'h01;
                     end
                  end
               end
               ST_SETTLE: begin
                  if (scnt_ff == 7'h00) begin
                     timing_state <= ST_FIXED;
                     scnt_ff <= `FIXED_GAP - 7'h01;
                  end else begin
                     scnt_ff <= scnt_ff - 7'h01;
                  end
               end
               ST_FIXED: begin
                  if (scnt_ff == 7'h00) begin
                     timing_state <= ST_PERIOD;
                     pcnt_ff <= period_load(period_ff);
                  end else begin
                     scnt_ff <= scnt_ff - 7'h01;
                  end
               end
               default: timing_state <= ST_PERIOD;
            endcase
         end
      end
   end

   // Mean-square power over the window; only whole windows are published.
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         acc_ff <= 47'h0;
         scnt_win_ff <= 19'h0;
         power_ff <= 32'h0000_0000;
         power_ok_ff <= 1'b0;
         low_power_flag <= 1'b0;
         high_power_flag <= 1'b0;
      end else if (measure_reset || sync_pulse || !rx_en) begin
         acc_ff <= 47'h0;
         scnt_win_ff <= 19'h0;
         power_ok_ff <= 1'b0;
      end else if (sample_valid) begin
         if (scnt_win_ff == win_len - 19'h1) begin
            // Power in -dBFS-ish units is left to software; the mean square is kept.
            power_ff <= mean_sq[31:0];
            power_ok_ff <= 1'b1;
            acc_ff <= 47'h0;
            scnt_win_ff <= 19'h0;
         end else begin
            acc_ff <= acc_next;
            scnt_win_ff <= scnt_win_ff + 19'h1;
         end
         // Thresholds compare the 8-bit code of the top power bits, larger code means quieter.
         low_power_flag <= power_ok_ff && (~power_ff[30:23] > thresh_ff[7:0]);
         high_power_flag <= power_ok_ff && (~power_ff[30:23] < thresh_ff[15:8]);
      end
   end
endmodule
`default_nettype wire

//--- design/agc_timing_defs.vh
`ifndef AGC_TIMING_DEFS_VH
`define AGC_TIMING_DEFS_VH
// Register byte offsets.
`define OFF_CTRL 8'h00
`define OFF_PERIOD 8'h04
`define OFF_SETTLE 8'h08
`define OFF_HOLD 8'h0c
`define OFF_WINDOW 8'h10
`define OFF_THRESH 8'h14
`define OFF_STATUS 8'h18
`define OFF_POWER 8'h1c
`define OFF_STROBE 8'h20
// Control register fields.
`define CTRL_RX_EN 0
`define CTRL_FAST_ATTACK 1
`define CTRL_BLOCK_EN 2
`define CTRL_FAST_REC 3
`define CTRL_SYNC_EN 4
`define CTRL_PIN_LO 8
// Reset values.
`define CTRL_RST 32'h0000_0006
`define PERIOD_RST 22'h002d00
`define SETTLE_RST 7'h10
`define HOLD_RST 6'h0a
`define WINDOW_RST 4'h0
`define THRESH_RST 16'h0000
// Timing and bus response codes.
`define FIXED_GAP 7'h05
`define WIN_BASE 19'h00008
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2
`endif

//--- testbench/agc_timing_props.sv
`timescale 1ns/1ps
`default_nettype none
module agc_timing_props (
   // Clock and reset.
   input wire clock,
   input wire rst,
   // Bus handshakes.
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire [31:0] s_axi_rdata,
   // Gain loop.
   input wire gain_decrease,
   input wire gain_increase,
   input wire measure_reset,
   input wire [1:0] timing_state
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   a_bvalid_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped early");
   a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped or changed early");
   a_aw_taken_soon: assert property ($rose(s_axi_awvalid) |-> ##[1:3] s_axi_awready)
      else $error("write address not taken");
   a_read_answered: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:3] s_axi_rvalid)
      else $error("read not answered");
   a_no_fourth_state: assert property (timing_state != 2'h3)
      else $error("illegal timing state");
   a_settle_then_fixed: assert property (timing_state == 2'h1 |=> timing_state != 2'h0)
      else $error("settle gap not followed by fixed delay");
   a_fixed_five: assert property ($rose(timing_state == 2'h2) |-> (timing_state == 2'h2)[*5] ##1 timing_state == 2'h0)
      else $error("fixed delay not five cycles");
   a_decrease_in_period: assert property (gain_decrease |-> timing_state == 2'h0)
      else $error("gain decrease outside period state");
   a_decrease_spaced: assert property (gain_decrease |=> !gain_decrease ##1 !gain_decrease)
      else $error("gain decreases too close");
   a_increase_at_end: assert property (gain_increase |-> measure_reset)
      else $error("gain increase away from period end");
endmodule
bind agc_power_detect_and_timing agc_timing_props u_props (.clock(clock), .rst(rst),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
   .gain_decrease(gain_decrease), .gain_increase(gain_increase),
   .measure_reset(measure_reset), .timing_state(timing_state));
`default_nettype wire

//--- testbench/slot_sync_source.sv
`timescale 1ns/1ps
`default_nettype none
module slot_sync_source (
   // Clock.
   input wire clock,
   // Pins toward the device.
   output reg [15:0] digital_gp_pin
);
   initial digital_gp_pin = 16'h0000;
   // Pulses last two clocks so that a two-flop synchroniser cannot miss them.
   task pulse(input [3:0] pin);
      begin
         @(posedge clock);
         digital_gp_pin[pin] <= 1'b1;
         repeat (2) @(posedge clock);
         digital_gp_pin[pin] <= 1'b0;
      end
   endtask
endmodule
`default_nettype wire

//--- testbench/agc_power_detect_and_timing_bench.sv
`timescale 1ns/1ps
`include "agc_timing_defs.vh"
`default_nettype none
module agc_power_detect_and_timing_bench;
   reg clock = 1'b0;
   reg rst = 1'b1;
   reg [7:0] awaddr = 8'h00;
   reg [7:0] araddr = 8'h00;
   reg [31:0] wdata = 32'h0;
   reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   reg attack = 1'b0, recover = 1'b0, low_done = 1'b0, svalid = 1'b0;
   reg [15:0] si = 16'h7fff, sq = 16'h0200;
   wire awready, wready, bvalid, arready, rvalid;
   wire dec, inc, mreset, lflag, hflag;
   wire [1:0] bresp, rresp, tstate;
   wire [31:0] rdata;
   wire [15:0] pins;
   integer err_count = 0, checked = 0, span, i, k;
   reg [1:0] resp;
   reg [31:0] got;
   always #2.5 clock = ~clock;
   slot_sync_source sync_src (.clock(clock), .digital_gp_pin(pins));
   agc_power_detect_and_timing dut (.clock(clock), .rst(rst), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sample_i(si),
      .sample_q(sq), .sample_valid(svalid), .attack_req(attack), .recover_req(recover),
      .low_interval_done(low_done), .digital_gp_pin(pins), .gain_decrease(dec),
      .gain_increase(inc), .measure_reset(mreset), .low_power_flag(lflag),
      .high_power_flag(hflag), .timing_state(tstate));
   task wrap_up;
      begin
         $display("checks %0d mismatches %0d", checked, err_count);
         if (err_count == 0 && checked > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   task check(input [31:0] seen, input [31:0] exp, input [63:0] what);
      begin
         checked = checked + 1;
         if (seen !== exp) begin
            err_count = err_count + 1;
            $display("BAD %0s expected %h seen %h", what, exp, seen);
         end
      end
   endtask
   task stuck;
      begin
         err_count = err_count + 1;
         $display("BAD wait limit reached");
         wrap_up;
      end
   endtask
   task axi_write(input [7:0] a, input [31:0] d);
      integer n;
      reg done;
      begin
         // An edge first, so a ready just released is never raised in the same step.
         @(posedge clock);
         awaddr <= a;
         wdata <= d;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
         done = 1'b0;
         for (n = 0; n < 60 && !done; n = n + 1) begin
            @(posedge clock);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
               resp = bresp;
               bready <= 1'b0;
               done = 1'b1;
            end
         end
         if (!done) stuck;
      end
   endtask
   task axi_read(input [7:0] a);
      integer n;
      reg done;
      begin
         @(posedge clock);
         araddr <= a;
         arvalid <= 1'b1;
         rready <= 1'b1;
         done = 1'b0;
         for (n = 0; n < 60 && !done; n = n + 1) begin
            @(posedge clock);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
               got = rdata;
               resp = rresp;
               rready <= 1'b0;
               done = 1'b1;
            end
         end
         if (!done) stuck;
      end
   endtask
   // Counts cycles until the timing state reads s; span holds the count.
   task wait_state(input [1:0] s);
      begin
         span = 0;
         while (tstate !== s && span < 400) begin
            @(posedge clock);
            span = span + 1;
         end
         if (span >= 400) stuck;
      end
   endtask
   initial begin
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      svalid <= 1'b1;
      @(posedge clock);
      axi_read(`OFF_CTRL);
      check(got, 32'h0000_0006, "ctrl");
      axi_read(`OFF_PERIOD);
      check(got, 32'd11520, "period");
      axi_read(`OFF_SETTLE);
      check(got, 32'd16, "settle");
      axi_read(`OFF_HOLD);
      check(got, 32'd10, "hold");
      axi_read(8'h3c);
      check(got, 32'h0, "unmapped");
      check(resp, 2'h2, "unmapr");
      axi_write(8'h3c, 32'h1);
      check(resp, 2'h2, "unmapw");
      axi_write(`OFF_PERIOD, 32'hffff_ffff);
      axi_read(`OFF_PERIOD);
      check(got, 32'd4194303, "permax");
      axi_write(`OFF_SETTLE, 32'hffff_ffff);
      axi_read(`OFF_SETTLE);
      check(got, 32'd127, "setmax");
      axi_write(`OFF_HOLD, 32'hffff_ffff);
      axi_read(`OFF_HOLD);
      check(got, 32'd63, "holdmax");
      axi_write(`OFF_PERIOD, 32'd40);
      axi_write(`OFF_SETTLE, 32'd4);
      axi_write(`OFF_HOLD, 32'd3);
      axi_write(`OFF_CTRL, 32'h0000_0007);
      wait_state(2'h1);
      wait_state(2'h0);
      k = span;
      wait_state(2'h1);
      check(k + span, 32'd49, "period");
      wait_state(2'h0);
      repeat (10) @(posedge clock);
      attack <= 1'b1;
      for (i = 0; i < 10 && dec !== 1'b1; i = i + 1) @(posedge clock);
      check(dec, 1'b1, "attack");
      @(posedge clock);
      for (k = 1; k < 100 && dec !== 1'b1; k = k + 1) @(posedge clock);
      check(k >= 4, 1'b1, "gapdec");
      attack <= 1'b0;
      recover <= 1'b1;
      wait_state(2'h1);
      k = 0;
      span = 0;
      for (i = 0; i < 49; i = i + 1) begin
         @(posedge clock);
         k = k + (inc === 1'b1);
         span = span + (mreset === 1'b1);
      end
      check(k, 1, "incs");
      check(span, 1, "mresets");
      recover <= 1'b0;
      axi_write(`OFF_CTRL, 32'h0000_0517);
      for (i = 5; i < 7; i = i + 1) begin
         wait_state(2'h1);
         wait_state(2'h0);
         repeat (10) @(posedge clock);
         sync_src.pulse(i[3:0]);
         wait_state(2'h1);
         if (i == 5)
            check(span >= 37 && span <= 44, 1'b1, "synced");
         else
            check(span < 30, 1'b1, "otherpin");
      end
      // Full-scale I gives a top power code of 8'hbf after inversion.
      wait_state(2'h0);
      repeat (20) @(posedge clock);
      check(lflag, 1'b1, "lowflag");
      check(hflag, 1'b0, "highflag");
      axi_read(`OFF_POWER);
      check(got, 32'h2001_8000, "power");
      axi_write(`OFF_THRESH, 32'h0000_c0ff);
      repeat (3) @(posedge clock);
      check(lflag, 1'b0, "lowoff");
      check(hflag, 1'b1, "highon");
      axi_write(`OFF_CTRL, 32'h0000_000f);
      wait_state(2'h0);
      repeat (60) @(posedge clock);
      check(tstate, 2'h0, "fastrec");
      low_done <= 1'b1;
      @(posedge clock);
      low_done <= 1'b0;
      wait_state(2'h1);
      check(span, 1, "lowdone");
      wrap_up;
   end
endmodule
`default_nettype wire
